// >>> shared/acst_pkg.sv
// Constants and types shared by the converter sequencer and its serial port.
// Assumes one system clock; all pin-side timing is measured on that clock.
package acst_pkg;

	// ==========================================================
	// Durations in master-clock periods
	localparam int unsigned CONV_MCLK       = 18;
	localparam int unsigned CAL_FULL_MCLK   = 125013;
	localparam int unsigned CAL_DAC_FS_MCLK = 111114;
	localparam int unsigned CAL_OFS_MCLK    = 13899;
	localparam int unsigned CNT_W           = 17;

	// ==========================================================
	// Word layout
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned CODE_W     = 12;
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned BITCNT_W   = 6;

	// Control word fields
	localparam int unsigned CTRL_CONV_BIT = 0;
	localparam int unsigned CTRL_CAL_BIT  = 1;
	localparam int unsigned CTRL_SEL_LSB  = 2;

	// Read word status fields
	localparam int unsigned STAT_BUSY_BIT = 15;
	localparam int unsigned STAT_CAL_BIT  = 14;
	localparam int unsigned STAT_ABRT_BIT = 13;

	// ==========================================================
	// Synchroniser slots
	localparam int unsigned PIN_MCLK  = 0;
	localparam int unsigned PIN_CONV  = 1;
	localparam int unsigned PIN_CAL   = 2;
	localparam int unsigned PIN_SCLK  = 3;
	localparam int unsigned PIN_SYNC  = 4;
	localparam int unsigned PIN_DIN   = 5;
	localparam int unsigned PIN_N     = 6;
	localparam logic [5:0]  PIN_RST   = 6'h3e;

	// ==========================================================
	// Reset values
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [11:0] CODE_RST = 12'h000;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ARMED    = 3'b001,
		ST_CONV     = 3'b010,
		ST_CAL_WAIT = 3'b011,
		ST_CAL      = 3'b100
	} acst_state_type;

	typedef enum logic [1:0] {
		CAL_FULL   = 2'b00,
		CAL_DAC_FS = 2'b01,
		CAL_OFS    = 2'b10,
		CAL_SPARE  = 2'b11
	} acst_cal_type;

endpackage : acst_pkg

// >>> shared/acst_ser_if.sv
// Signals between the sequencer and its serial port engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface acst_ser_if;
	import acst_pkg::*;
	logic              sclk_lvl;
	logic              sync_n_lvl;
	logic              din_lvl;
	logic [WORD_W-1:0] rd_word;
	logic [WORD_W-1:0] wr_word;
	logic              wr_valid;
	logic              abort;
	logic              dout;
	logic              dout_oe;
	logic              din_out;
	logic              din_oe;

	modport ctl (
		output sclk_lvl, sync_n_lvl, din_lvl, rd_word,
		input  wr_word, wr_valid, abort, dout, dout_oe, din_out, din_oe
	);
	modport port (
		input  sclk_lvl, sync_n_lvl, din_lvl, rd_word,
		output wr_word, wr_valid, abort, dout, dout_oe, din_out, din_oe
	);
endinterface : acst_ser_if

// >>> hdl/acst_serial.sv
// Framed serial port, bidirectional data-line mode.
// Assumes synchronised pin levels on the interface, one system clock.
`timescale 1ns/1ns
module acst_serial
	import acst_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	acst_ser_if.port  bus
);

	logic                sclk_d_reg, sclk_d_next;
	logic                sync_d_reg, sync_d_next;
	logic                act_reg, act_next;
	logic [BITCNT_W-1:0] cnt_reg, cnt_next;
	logic [WORD_W-1:0]   shin_reg, shin_next;
	logic [WORD_W-1:0]   shout_reg, shout_next;
	logic [WORD_W-1:0]   wr_reg, wr_next;
	logic                wv_reg, wv_next;
	logic                ab_reg, ab_next;
	logic                doe_reg, doe_next;
	logic                ioe_reg, ioe_next;
	logic                sync_fall, sync_rise, sclk_fall, sclk_rise;

	assign sync_fall = sync_d_reg & ~bus.sync_n_lvl;
	assign sync_rise = ~sync_d_reg & bus.sync_n_lvl;
	assign sclk_fall = sclk_d_reg & ~bus.sclk_lvl;
	assign sclk_rise = ~sclk_d_reg & bus.sclk_lvl;

	// ==========================================================
	// Frame engine
	always_comb begin
		sclk_d_next = bus.sclk_lvl;
		sync_d_next = bus.sync_n_lvl;
		act_next    = act_reg;
		cnt_next    = cnt_reg;
		shin_next   = shin_reg;
		shout_next  = shout_reg;
		wr_next     = wr_reg;
		wv_next     = 1'b0;
		ab_next     = 1'b0;
		doe_next    = doe_reg;
		ioe_next    = ioe_reg;
		if (sync_fall) begin
			act_next   = 1'b1;
			cnt_next   = '0;
			shout_next = bus.rd_word;
			doe_next   = 1'b1;
			ioe_next   = 1'b0;
		end else if (sync_rise) begin
			// Partial write words are dropped, never applied
			ab_next  = act_reg && (cnt_reg < BITCNT_W'(FRAME_BITS));
			act_next = 1'b0;
			doe_next = 1'b0;
			ioe_next = 1'b0;
		end else if (act_reg && sclk_fall) begin
			// First fall after turnaround keeps the freshly loaded MSB
			if (cnt_reg != BITCNT_W'(FRAME_BITS)) begin
				shout_next = {shout_reg[WORD_W-2:0], 1'b0};
			end
		end else if (act_reg && sclk_rise) begin
			cnt_next = cnt_reg + 1'b1;
			if (cnt_reg < BITCNT_W'(FRAME_BITS)) begin
				shin_next = {shin_reg[WORD_W-2:0], bus.din_lvl};
			end
			if (cnt_reg == BITCNT_W'(FRAME_BITS - 1)) begin
				wr_next    = {shin_reg[WORD_W-2:0], bus.din_lvl};
				wv_next    = 1'b1;
				shout_next = bus.rd_word;
				ioe_next   = 1'b1;
			end
			if (cnt_reg == BITCNT_W'(2 * FRAME_BITS - 1)) begin
				ioe_next = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sclk_d_reg <= 1'b0;
			sync_d_reg <= 1'b1;
			act_reg    <= 1'b0;
			cnt_reg    <= '0;
			shin_reg   <= WORD_RST;
			shout_reg  <= WORD_RST;
			wr_reg     <= WORD_RST;
			wv_reg     <= 1'b0;
			ab_reg     <= 1'b0;
			doe_reg    <= 1'b0;
			ioe_reg    <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_d_next;
			sync_d_reg <= sync_d_next;
			act_reg    <= act_next;
			cnt_reg    <= cnt_next;
			shin_reg   <= shin_next;
			shout_reg  <= shout_next;
			wr_reg     <= wr_next;
			wv_reg     <= wv_next;
			ab_reg     <= ab_next;
			doe_reg    <= doe_next;
			ioe_reg    <= ioe_next;
		end
	end

	assign bus.wr_word  = wr_reg;
	assign bus.wr_valid = wv_reg;
	assign bus.abort    = ab_reg;
	assign bus.dout     = shout_reg[WORD_W-1];
	assign bus.dout_oe  = doe_reg;
	assign bus.din_out  = shout_reg[WORD_W-1];
	assign bus.din_oe   = ioe_reg;

endmodule : acst_serial

// >>> hdl/acst_top.sv
// Conversion and calibration sequencer with framed serial port.
// Assumes pins are asynchronous to i_clk; all but i_cal_select and i_sample_code pass two flip-flops.
// Functional notes
// - Conversion lasts exactly 18 master-clock periods
// - Full self-calibration lasts 125013 master periods
// - DAC plus full-scale calibration: 111114 periods
// - System offset calibration lasts 13899 periods
// - Busy rises soon after calibrate deasserts
// - Convert-start fall during calibration keeps busy
// - Start by pin or control word
// - Frame sync fall enables serial output
// - Frame sync fall sets data line to input
// - Frame sync rise releases serial output
// - Output data changes after clock fall
// - Data line turns output on clock rise
// - Data line returns input on clock rise
// - Busy high for whole operation
// - Convert-start rise holds and starts conversion
`timescale 1ns/1ns
module acst_top
	import acst_pkg::*;
#(
	parameter logic [CNT_W-1:0] P_CAL_FULL   = CNT_W'(CAL_FULL_MCLK),
	parameter logic [CNT_W-1:0] P_CAL_DAC_FS = CNT_W'(CAL_DAC_FS_MCLK),
	parameter logic [CNT_W-1:0] P_CAL_OFS    = CNT_W'(CAL_OFS_MCLK)
)(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_master_clock_in,
	input  wire logic              i_convert_start_n,
	input  wire logic              i_cal_n,
	input  wire logic [1:0]        i_cal_select,
	input  wire logic [CODE_W-1:0] i_sample_code,
	input  wire logic              i_sclk,
	input  wire logic              i_sync_n,
	input  wire logic              i_din,
	output logic                   o_din,
	output logic                   o_din_oe,
	output logic                   o_dout,
	output logic                   o_dout_oe,
	output logic                   o_busy,
	output logic                   o_hold,
	output logic [WORD_W-1:0]      o_ctrl_word,
	output logic                   o_ctrl_valid
);

	// ==========================================================
	// Decoding
	function automatic logic [CNT_W-1:0] cal_len(input logic [1:0] sel);
		logic [CNT_W-1:0] len;
		case (acst_cal_type'(sel))
			CAL_DAC_FS: len = P_CAL_DAC_FS;
			CAL_OFS:    len = P_CAL_OFS;
			default:    len = P_CAL_FULL;
		endcase
		return len;
	endfunction : cal_len

	// ==========================================================
	// Pin synchronisers
	// Two stages; the second stage and its one-clock delayed copy feed logic
	logic [PIN_N-1:0] meta_reg, meta_next;
	logic [PIN_N-1:0] sync_reg, sync_next;
	logic [PIN_N-1:0] prev_reg, prev_next;
	logic [PIN_N-1:0] pins;
	logic [PIN_N-1:0] rise;
	logic [PIN_N-1:0] fall;

	assign pins[PIN_MCLK] = i_master_clock_in;
	assign pins[PIN_CONV] = i_convert_start_n;
	assign pins[PIN_CAL]  = i_cal_n;
	assign pins[PIN_SCLK] = i_sclk;
	assign pins[PIN_SYNC] = i_sync_n;
	assign pins[PIN_DIN]  = i_din;

	always_comb begin
		meta_next = pins;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_reg <= PIN_RST;
			sync_reg <= PIN_RST;
			prev_reg <= PIN_RST;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	genvar g;
	generate
		for (g = 0; g < PIN_N; g++) begin : g_edge
			assign rise[g] = ~prev_reg[g] & sync_reg[g];
			assign fall[g] = prev_reg[g] & ~sync_reg[g];
		end
	endgenerate

	// ==========================================================
	// Serial port
	acst_ser_if ser ();

	assign ser.sclk_lvl   = sync_reg[PIN_SCLK];
	assign ser.sync_n_lvl = sync_reg[PIN_SYNC];
	assign ser.din_lvl    = sync_reg[PIN_DIN];

	acst_serial u_serial (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.bus     (ser)
	);

	// Software requests from a completed control word
	logic sw_conv;
	logic sw_cal;

	assign sw_conv = ser.wr_valid & ser.wr_word[CTRL_CONV_BIT];
	assign sw_cal  = ser.wr_valid & ser.wr_word[CTRL_CAL_BIT];

	// ==========================================================
	// Sequencer
	acst_state_type      state_reg, state_next;
	logic [CNT_W-1:0]    cnt_reg, cnt_next;
	logic                busy_reg, busy_next;
	logic                hold_reg, hold_next;
	logic [1:0]          sel_reg, sel_next;
	logic [CODE_W-1:0]   code_reg, code_next;
	logic [CODE_W-1:0]   res_reg, res_next;
	logic                abrt_reg, abrt_next;
	logic [WORD_W-1:0]   cw_reg, cw_next;
	logic                cv_reg, cv_next;
	logic                expire;

	// Expiry only on a master edge, so busy drops on that edge
	assign expire = rise[PIN_MCLK] && (cnt_reg == CNT_W'(1));

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		busy_next  = busy_reg;
		hold_next  = hold_reg;
		sel_next   = sel_reg;
		code_next  = code_reg;
		res_next   = res_reg;
		abrt_next  = abrt_reg | ser.abort;
		cw_next    = cw_reg;
		cv_next    = 1'b0;
		if (ser.wr_valid) begin
			cw_next   = ser.wr_word;
			cv_next   = 1'b1;
			abrt_next = 1'b0;
		end
		if (rise[PIN_MCLK] && (cnt_reg != '0)) begin
			cnt_next = cnt_reg - 1'b1;
		end
		case (state_reg)
			ST_IDLE: begin
				if (fall[PIN_CONV]) begin
					busy_next  = 1'b1;
					state_next = ST_ARMED;
				end else if (sw_conv) begin
					// Control word start: hold and count at once
					busy_next  = 1'b1;
					hold_next  = 1'b1;
					code_next  = i_sample_code;
					cnt_next   = CNT_W'(CONV_MCLK);
					state_next = ST_CONV;
				end else if (fall[PIN_CAL]) begin
					sel_next   = i_cal_select;
					state_next = ST_CAL_WAIT;
				end else if (sw_cal) begin
					sel_next   = ser.wr_word[CTRL_SEL_LSB +: 2];
					busy_next  = 1'b1;
					cnt_next   = cal_len(ser.wr_word[CTRL_SEL_LSB +: 2]);
					state_next = ST_CAL;
				end
			end
			ST_ARMED: begin
				if (rise[PIN_CONV]) begin
					hold_next  = 1'b1;
					code_next  = i_sample_code;
					cnt_next   = CNT_W'(CONV_MCLK);
					state_next = ST_CONV;
				end
			end
			ST_CONV: begin
				// Edges on convert-start change nothing here
				if (expire) begin
					busy_next  = 1'b0;
					hold_next  = 1'b0;
					res_next   = code_reg;
					state_next = ST_IDLE;
				end
			end
			ST_CAL_WAIT: begin
				if (rise[PIN_CAL]) begin
					busy_next  = 1'b1;
					cnt_next   = cal_len(sel_reg);
					state_next = ST_CAL;
				end
			end
			ST_CAL: begin
				// Busy already high; a convert-start fall keeps it so
				busy_next = 1'b1;
				if (expire) begin
					busy_next  = 1'b0;
					state_next = ST_IDLE;
				end
			end
			default: begin
				busy_next  = 1'b0;
				hold_next  = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
	end
	// Only ST_IDLE accepts a start, so nothing restarts mid-operation

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
			busy_reg  <= 1'b0;
			hold_reg  <= 1'b0;
			sel_reg   <= CAL_FULL;
			code_reg  <= CODE_RST;
			res_reg   <= CODE_RST;
			abrt_reg  <= 1'b0;
			cw_reg    <= WORD_RST;
			cv_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			busy_reg  <= busy_next;
			hold_reg  <= hold_next;
			sel_reg   <= sel_next;
			code_reg  <= code_next;
			res_reg   <= res_next;
			abrt_reg  <= abrt_next;
			cw_reg    <= cw_next;
			cv_reg    <= cv_next;
		end
	end

	// ==========================================================
	// Read word and outputs
	always_comb begin
		ser.rd_word                = {{(WORD_W-CODE_W){1'b0}}, res_reg};
		ser.rd_word[STAT_BUSY_BIT] = busy_reg;
		ser.rd_word[STAT_CAL_BIT]  = (state_reg == ST_CAL);
		ser.rd_word[STAT_ABRT_BIT] = abrt_reg;
	end

	assign o_busy       = busy_reg;
	assign o_hold       = hold_reg;
	assign o_ctrl_word  = cw_reg;
	assign o_ctrl_valid = cv_reg;
	assign o_dout       = ser.dout;
	assign o_dout_oe    = ser.dout_oe;
	assign o_din        = ser.din_out;
	assign o_din_oe     = ser.din_oe;

endmodule : acst_top

// >>> verification/acst_host_model.sv
// Host serial port model: frames on sync, serial clock and data line.
// Assumes the bench starts frames; serial clock idles low.
`timescale 1ns/1ns
module acst_host_model (
	input  wire logic i_clk,
	input  wire logic i_din,
	input  wire logic i_din_oe,
	input  wire logic i_dout,
	output logic      o_sclk,
	output logic      o_sync_n,
	output logic      o_line
);
	logic drv = 1'b0;
	logic bv  = 1'b0;
	logic rel = 1'b0;
	// Released line toggles so a stale bit never passes as data
	assign o_line = i_din_oe ? i_din : (drv ? bv : rel);
	always @(posedge i_clk) rel <= (o_line === 1'b1) ? 1'b0 : 1'b1;
	initial begin
		o_sclk = 1'b0;
		o_sync_n = 1'b1;
	end
	// ========
	// Frame: 62/63 ns halves keep edges off the system clock edge
	task automatic frame(input logic [15:0] wr, input int nr, output logic [15:0] rd, output logic [15:0] rb);
		@(posedge i_clk);
		#6;
		rd = 16'h0000;
		rb = 16'h0000;
		drv = 1'b1;
		o_sync_n = 1'b0;
		for (int i = 0; i < nr; i++) begin
			if (i < 16) bv = wr[15 - i];
			#62;
			o_sclk = 1'b1;
			if (i < 16) rd[15 - i] = i_dout;
			if (i >= 16 && i < 32) rb[31 - i] = i_din;
			#20;
			if (i == 15) drv = 1'b0;
			#43;
			o_sclk = 1'b0;
		end
		#20;
		o_sync_n = 1'b1;
		#60;
	endtask : frame
endmodule : acst_host_model

// >>> verification/acst_top_checker.sv
// Pin-level assertions for the sequencer and serial port.
// Assumes pin edges reach outputs three to four clocks later.
`timescale 1ns/1ns
module acst_top_checker (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_master_clock_in,
	input wire logic i_convert_start_n,
	input wire logic i_cal_n,
	input wire logic i_sclk,
	input wire logic i_sync_n,
	input wire logic o_dout,
	input wire logic o_dout_oe,
	input wire logic o_din_oe,
	input wire logic o_busy,
	input wire logic o_hold,
	input wire logic o_ctrl_valid
);
	logic [5:0] mcnt_reg;
	logic [5:0] mcnt_next;
	logic       mprev_reg;
	// ========
	// Master rises seen while in hold
	always_comb begin
		mcnt_next = mcnt_reg;
		if (!o_hold)
			mcnt_next = 6'h00;
		else if (i_master_clock_in && !mprev_reg)
			mcnt_next = mcnt_reg + 6'h01;
	end
	always_ff @(posedge i_clk) begin
		mcnt_reg  <= i_rst_n ? mcnt_next : 6'h00;
		mprev_reg <= i_master_clock_in;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ========
	// Properties
	property p_conv_busy; $fell(i_convert_start_n) && !o_busy && i_cal_n |-> ##[1:5] o_busy; endproperty
	a_conv_busy: assert property (p_conv_busy) else $error("busy late on start");
	property p_cal_busy; $rose(i_cal_n) && !o_busy |-> ##[1:5] o_busy; endproperty
	a_cal_busy: assert property (p_cal_busy) else $error("busy late on calibrate");
	property p_hold_busy; o_hold |-> o_busy; endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("hold without busy");
	property p_conv_len; $fell(o_hold) |-> mcnt_reg == 6'h12; endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	property p_out_on; $fell(i_sync_n) |-> ##[1:5] o_dout_oe; endproperty
	a_out_on: assert property (p_out_on) else $error("output not driven");
	property p_out_off; $rose(i_sync_n) |-> ##[1:5] !o_dout_oe; endproperty
	a_out_off: assert property (p_out_off) else $error("output not released");
	property p_line_turn; $rose(o_din_oe) |-> ##1 o_ctrl_valid; endproperty
	a_line_turn: assert property (p_line_turn) else $error("turnaround early");
	property p_shift; $changed(o_dout) && o_dout_oe && $past(o_dout_oe) && $stable(o_din_oe) |-> !$past(i_sclk, 3);
	endproperty
	a_shift: assert property (p_shift) else $error("output changed off clock fall");
	c_conv: cover property ($fell(o_hold));
	c_word: cover property (o_ctrl_valid);
	c_cal: cover property ($fell(o_busy) && !$past(o_hold));
endmodule : acst_top_checker

// >>> verification/tb.sv
// Self-checking bench for the converter sequencer and serial port.
// Assumes 100 MHz system clock, 4 MHz master clock, 125 ns serial clock.
`timescale 1ns/1ns
module tb;
	import acst_pkg::*;
	logic        clk, rst_n, mclk, conv_n, cal_n, sclk, sync_n, line;
	logic        din, din_oe, dout, dout_oe, busy, hold, cvalid, abrt;
	logic [1:0]  sel;
	logic [11:0] code, pub;
	logic [15:0] cword, got, lfsr;
	logic [15:0] cal_len [4] = '{16'h0014, 16'h000f, 16'h000a, 16'h0014};
	int          err_count = 0, n_tests = 0, nvalid = 0, cyc = 0, n;
	acst_top #(.P_CAL_FULL(17'h00014), .P_CAL_DAC_FS(17'h0000f), .P_CAL_OFS(17'h0000a)) i_dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_master_clock_in(mclk), .i_convert_start_n(conv_n),
		.i_cal_n(cal_n), .i_cal_select(sel), .i_sample_code(code), .i_sclk(sclk), .i_sync_n(sync_n),
		.i_din(line), .o_din(din), .o_din_oe(din_oe), .o_dout(dout), .o_dout_oe(dout_oe),
		.o_busy(busy), .o_hold(hold), .o_ctrl_word(cword), .o_ctrl_valid(cvalid));
	acst_host_model i_host (.i_clk(clk), .i_din(din), .i_din_oe(din_oe), .i_dout(dout),
		.o_sclk(sclk), .o_sync_n(sync_n), .o_line(line));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		mclk = 1'b0;
		#2;
		forever #125 mclk = ~mclk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cvalid === 1'b1) begin
			nvalid <= nvalid + 1;
			got    <= cword;
		end
		if (cyc == 30000) begin
			err_count++;
			results();
		end
	end
	// ========
	// Tasks
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	// Master rises until busy drops; next rise is 25 clocks away
	task automatic count_rises(output int c);
		logic p;
		p = mclk;
		c = 0;
		while (busy === 1'b1 && c < 200) begin
			@(negedge clk);
			if (mclk && !p) c++;
			p = mclk;
		end
	endtask : count_rises
	task automatic xfer(input logic [15:0] wr, input int nr, input logic [1:0] st);
		int          v;
		logic [15:0] r, b, e;
		v = nvalid;
		e = {st, abrt, 1'b0, pub};
		if (nr < 16) e = e & ~(16'hffff >> nr);
		@(posedge mclk);
		i_host.frame(wr, nr, r, b);
		repeat (5) @(negedge clk);
		check(r, e);
		if (nr >= 32) check(b, {st, abrt, 1'b0, pub});
		check(16'(nvalid - v), 16'(nr >= 16));
		if (nr >= 16) check(got, wr);
		abrt = (nr < 16);
	endtask : xfer
	// ========
	// Sequence
	initial begin
		rst_n = 1'b0; conv_n = 1'b1; cal_n = 1'b1; sel = 2'h0; code = 12'h000; pub = 12'h000; abrt = 1'b0;
		lfsr = 16'h0057;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			lfsr = nxt(lfsr);
			code <= lfsr[11:0];
			@(posedge clk) conv_n <= 1'b0;
			repeat (5) @(negedge clk);
			check(busy, 1'b1);
			@(posedge mclk);
			@(posedge clk) conv_n <= 1'b1;
			fork
				count_rises(n);
				begin
					repeat (60) @(posedge clk);
					conv_n <= 1'b0;
					repeat (20) @(posedge clk);
					conv_n <= 1'b1;
				end
			join
			check(16'(n), 16'h0012);
			pub = code;
			repeat (40) @(posedge clk);
			xfer({lfsr[15:2], 2'b00}, 32, 2'b00);
		end
		for (int s = 0; s < 4; s++) begin
			sel <= 2'(s);
			@(posedge clk) cal_n <= 1'b0;
			repeat (10) @(posedge clk);
			@(posedge mclk);
			@(posedge clk) cal_n <= 1'b1;
			repeat (5) @(negedge clk);
			check(busy, 1'b1);
			fork
				count_rises(n);
				begin
					@(posedge clk) conv_n <= 1'b0;
					repeat (5) @(negedge clk);
					check(busy, 1'b1);
					@(posedge clk) conv_n <= 1'b1;
				end
			join
			check(16'(n), cal_len[s]);
			repeat (40) @(posedge clk);
		end
		xfer(16'h0000, 8, 2'b00);
		xfer(16'h00f0, 32, 2'b00);
		lfsr = nxt(lfsr);
		code <= lfsr[11:0];
		xfer(16'h0001, 16, 2'b00);
		xfer(16'h0000, 16, 2'b10);
		for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge clk);
		check(busy, 1'b0);
		pub = code;
		xfer(16'h0000, 16, 2'b00);
		results();
	end
endmodule : tb
bind acst_top acst_top_checker i_chk (.i_clk, .i_rst_n, .i_master_clock_in, .i_convert_start_n, .i_cal_n,
	.i_sclk, .i_sync_n, .o_dout, .o_dout_oe, .o_din_oe, .o_busy, .o_hold, .o_ctrl_valid);
